// *** tma_pkg.sv ***
// Shared constants and carriers for the lookaside miss assist block
package tma_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0] OFF_INSTR_MISS_ADDR  = 8'h00;
  localparam logic [7:0] OFF_DATA_MISS_ADDR   = 8'h04;
  localparam logic [7:0] OFF_PRIMARY_GROUP    = 8'h08;
  localparam logic [7:0] OFF_SECONDARY_GROUP  = 8'h0C;
  localparam logic [7:0] OFF_INSTR_COMPARE    = 8'h10;
  localparam logic [7:0] OFF_DATA_COMPARE     = 8'h14;
  localparam logic [7:0] OFF_RELOAD_PHYS_ADDR = 8'h18;
  localparam logic [7:0] OFF_TABLE_BASE       = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS       = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLEAR        = 8'h24;
  localparam logic [7:0] OFF_IRQ_ENABLE       = 8'h28;
  localparam logic [7:0] OFF_MACHINE_STATE    = 8'h2C;
  localparam logic [7:0] OFF_SAVE_RESTORE_ONE = 8'h30;
  localparam logic [7:0] OFF_SEGMENT_BASE     = 8'h40;
  localparam int         SEGMENT_COUNT        = 16;

  // Reset values
  localparam logic [31:0] RST_WORD         = 32'h0000_0000;
  localparam logic [31:0] RST_TABLE_BASE   = 32'h0000_0000;
  localparam logic [2:0]  RST_IRQ_ENABLE   = 3'h0;

  // Machine state field positions
  localparam int MS_SCRATCH_SEL = 17;
  localparam int MS_INSTR_XLATE = 5;
  localparam int MS_DATA_XLATE  = 4;

  // Save/restore one field positions
  localparam int SR_COND_HI = 31;
  localparam int SR_COND_LO = 28;
  localparam int SR_KEY     = 19;
  localparam int SR_INSTR   = 18;
  localparam int SR_WAY     = 17;
  localparam int SR_STORE   = 16;

  // Interrupt status bit positions
  localparam int IRQ_INSTR_MISS = 0;
  localparam int IRQ_DATA_MISS  = 1;
  localparam int IRQ_TLB_LOAD   = 2;

  // Default memory attributes in real mode and the translated fetch mask (write-through, inhibit, coherent, guarded)
  localparam logic [3:0] ATTR_REAL_DATA  = 4'h3;
  localparam logic [3:0] ATTR_REAL_INSTR = 4'h1;
  localparam logic [3:0] ATTR_ICACHE_MASK = 4'h5;

  // Access sizes for byte-order correction
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [2:0] MUNGE_BYTE = 3'h7;
  localparam logic [2:0] MUNGE_HALF = 3'h6;
  localparam logic [2:0] MUNGE_WORD = 3'h4;

  typedef struct packed {
    logic        isInstr;
    logic        isStore;
    logic        protKey;
    logic [1:0]  size;
    logic [31:0] ea;
  } tma_miss_s;

  typedef struct packed {
    logic [31:0] cmpWord;
    logic [31:0] physWord;
    logic        way;
  } tma_entry_s;

endpackage

// *** tma_group_hash.sv ***
// Page entry group hash and compare word former
`timescale 1ns/1ns
module tma_group_hash
  import tma_pkg::*;
(
  input  wire logic [31:0] missAddr,
  input  wire logic [31:0] segWord,
  input  wire logic [31:0] tableBase,
  output logic      [31:0] primaryAddr,
  output logic      [31:0] secondaryAddr,
  output logic      [31:0] compareWord
);
  logic [18:0] primHash;
  logic [18:0] secHash;

  // Low 19 bits of segment id against the page index
  assign primHash = segWord[18:0] ^ {3'h0, missAddr[27:12]};
  assign secHash  = ~primHash;

  // Table base high bits, upper hash bits gated by the table size mask
  assign primaryAddr   = {tableBase[31:25], tableBase[24:16] | (primHash[18:10] & tableBase[8:0]),
                          primHash[9:0], 6'h00};
  assign secondaryAddr = {tableBase[31:25], tableBase[24:16] | (secHash[18:10] & tableBase[8:0]),
                          secHash[9:0], 6'h00};
  // Valid, segment id, primary hash flag clear, abbreviated page index
  assign compareWord   = {1'b1, segWord[23:0], 1'b0, missAddr[27:22]};
endmodule // tma_group_hash

// *** tma_miss_assist.sv ***
// Lookaside miss assist, scratch register steering and real mode defaults
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module tma_miss_assist
  import tma_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side events
  input  wire logic        missTake,
  input  wire tma_miss_s   missInfo,
  input  wire logic        littleEndian,
  input  wire logic [3:0]  condFieldZero,
  input  wire logic        rfiTake,
  input  wire logic        tlbLoadInstr,
  input  wire logic        tlbLoadData,
  input  wire logic [4:0]  gprIndex,
  input  wire logic        accValid,
  input  wire logic        accIsFetch,
  input  wire logic [31:0] accEa,
  input  wire logic [3:0]  accXlateAttr,
  // Results
  output logic [5:0]       gprSlot,
  output logic             instrLookasideWe,
  output logic             dataLookasideWe,
  output tma_entry_s       lookasideEntry,
  output logic             realValid,
  output logic             xlateNeeded,
  output logic [31:0]      physAddr,
  output logic [3:0]       memAttr,
  output logic             scratchSelect,
  output logic [31:0]      saveRestoreOne,
  output logic             irq
);

  // Register state
  logic [31:0] instrMissAddr_q, dataMissAddr_q;
  logic [31:0] primaryGroup_q, secondaryGroup_q;
  logic [31:0] instrCompare_q, dataCompare_q;
  logic [31:0] reloadPhys_q, tableBase_q;
  logic [31:0] machineState_q, saveRestore_q;
  logic [2:0]  irqStatus_q, irqEnable_q;
  logic        instrWay_q, dataWay_q;
  logic [31:0] segReg_q    [SEGMENT_COUNT];
  logic [31:0] segShadow_q [SEGMENT_COUNT];

  // Bus handshake: one wait state so read data leaves a flip-flop
  logic        pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic        accessPhase, firstAccess, commitWrite;
  assign accessPhase = psel & penable;
  assign firstAccess = accessPhase & ~pready_q;
  assign commitWrite = accessPhase & pready_q & pwrite & ~pslverr_q;

  // Address decode
  logic        selSegment, mapped, writeable;
  logic [3:0]  segIndex;
  assign selSegment = (paddr[7:6] == OFF_SEGMENT_BASE[7:6]) & (paddr[1:0] == 2'h0);
  assign segIndex   = paddr[5:2];
  assign writeable  = (paddr == OFF_RELOAD_PHYS_ADDR) | (paddr == OFF_TABLE_BASE) |
                      (paddr == OFF_IRQ_CLEAR) | (paddr == OFF_IRQ_ENABLE) |
                      (paddr == OFF_MACHINE_STATE) | selSegment;
  assign mapped     = writeable | selSegment |
                      (paddr == OFF_INSTR_MISS_ADDR) | (paddr == OFF_DATA_MISS_ADDR) |
                      (paddr == OFF_PRIMARY_GROUP) | (paddr == OFF_SECONDARY_GROUP) |
                      (paddr == OFF_INSTR_COMPARE) | (paddr == OFF_DATA_COMPARE) |
                      (paddr == OFF_IRQ_STATUS) | (paddr == OFF_SAVE_RESTORE_ONE);

  // Clear register is write-only and reads as zero
  logic [31:0] readWord;
  assign readWord =
    selSegment                       ? segReg_q[segIndex] :
    (paddr == OFF_INSTR_MISS_ADDR)   ? instrMissAddr_q :
    (paddr == OFF_DATA_MISS_ADDR)    ? dataMissAddr_q :
    (paddr == OFF_PRIMARY_GROUP)     ? primaryGroup_q :
    (paddr == OFF_SECONDARY_GROUP)   ? secondaryGroup_q :
    (paddr == OFF_INSTR_COMPARE)     ? instrCompare_q :
    (paddr == OFF_DATA_COMPARE)      ? dataCompare_q :
    (paddr == OFF_RELOAD_PHYS_ADDR)  ? reloadPhys_q :
    (paddr == OFF_TABLE_BASE)        ? tableBase_q :
    (paddr == OFF_IRQ_STATUS)        ? {29'h0, irqStatus_q} :
    (paddr == OFF_IRQ_ENABLE)        ? {29'h0, irqEnable_q} :
    (paddr == OFF_MACHINE_STATE)     ? machineState_q :
    (paddr == OFF_SAVE_RESTORE_ONE)  ? saveRestore_q : 32'h0000_0000;

  // Write strobes
  logic wrReload, wrTable, wrClear, wrEnable, wrMachine, wrSegment;
  assign wrReload  = commitWrite & (paddr == OFF_RELOAD_PHYS_ADDR);
  assign wrTable   = commitWrite & (paddr == OFF_TABLE_BASE);
  assign wrClear   = commitWrite & (paddr == OFF_IRQ_CLEAR);
  assign wrEnable  = commitWrite & (paddr == OFF_IRQ_ENABLE);
  assign wrMachine = commitWrite & (paddr == OFF_MACHINE_STATE);
  assign wrSegment = commitWrite & selSegment;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RST_WORD;
    end else if (ce) begin
      pready_q  <= firstAccess;
      pslverr_q <= firstAccess & (~mapped | (pwrite & ~writeable));
      prdata_q  <= (firstAccess & ~pwrite & mapped) ? readWord : RST_WORD;
    end
  end

  // Byte-order correction of a munged little-endian data address
  logic [2:0]  mungeBits;
  logic [31:0] missAddrBig;
  assign mungeBits   = (missInfo.size == SIZE_BYTE) ? MUNGE_BYTE :
                       (missInfo.size == SIZE_HALF) ? MUNGE_HALF :
                       (missInfo.size == SIZE_WORD) ? MUNGE_WORD : 3'h0;
  assign missAddrBig = (littleEndian & ~missInfo.isInstr) ?
                       {missInfo.ea[31:3], missInfo.ea[2:0] ^ mungeBits} :
                       missInfo.ea;

  // Instruction side hashes through its hidden shadow segment copy
  logic [31:0] segWordMiss;
  assign segWordMiss = missInfo.isInstr ? segShadow_q[missAddrBig[31:28]] :
                                          segReg_q[missAddrBig[31:28]];

  logic [31:0] hashPrimary, hashSecondary, hashCompare;
  tma_group_hash u_hash (
    .missAddr      (missAddrBig),
    .segWord       (segWordMiss),
    .tableBase     (tableBase_q),
    .primaryAddr   (hashPrimary),
    .secondaryAddr (hashSecondary),
    .compareWord   (hashCompare)
  );

  // Miss capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instrMissAddr_q  <= RST_WORD;
      dataMissAddr_q   <= RST_WORD;
      primaryGroup_q   <= RST_WORD;
      secondaryGroup_q <= RST_WORD;
      instrCompare_q   <= RST_WORD;
      dataCompare_q    <= RST_WORD;
    end else if (ce && missTake) begin
      primaryGroup_q   <= hashPrimary;
      secondaryGroup_q <= hashSecondary;
      if (missInfo.isInstr) begin
        instrMissAddr_q <= missAddrBig;
        instrCompare_q  <= hashCompare;
      end else begin
        dataMissAddr_q  <= missAddrBig;
        dataCompare_q   <= hashCompare;
      end
    end
  end

  // Segment registers; the shadow follows every write but is never read back on the bus
  genvar gi;
  generate
    for (gi = 0; gi < SEGMENT_COUNT; gi++) begin : g_seg
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          segReg_q[gi]    <= RST_WORD;
          segShadow_q[gi] <= RST_WORD;
        end else if (ce && wrSegment && segIndex == gi[3:0]) begin
          segReg_q[gi]    <= pwdata;
          segShadow_q[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // Software-loaded words
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reloadPhys_q <= RST_WORD;
      tableBase_q  <= RST_TABLE_BASE;
      irqEnable_q  <= RST_IRQ_ENABLE;
    end else if (ce) begin
      if (wrReload) reloadPhys_q <= pwdata;
      if (wrTable)  tableBase_q  <= pwdata;
      if (wrEnable) irqEnable_q  <= pwdata[2:0];
    end
  end

  // Machine state and save/restore one; hardware events win over a bus write
  logic [31:0] missSave;
  logic        missWay;
  assign missWay = missInfo.isInstr ? instrWay_q : dataWay_q;
  always_comb begin
    missSave                        = machineState_q;
    missSave[SR_COND_HI:SR_COND_LO] = condFieldZero;
    missSave[SR_KEY]                = missInfo.protKey;
    missSave[SR_INSTR]              = missInfo.isInstr;
    missSave[SR_WAY]                = missWay;
    missSave[SR_STORE]              = missInfo.isStore;
  end

  logic [31:0] machineNext;
  always_comb begin
    machineNext = wrMachine ? pwdata : machineState_q;
    if (missTake) begin
      machineNext[MS_SCRATCH_SEL] = 1'b1;
      machineNext[MS_INSTR_XLATE] = 1'b0;
      machineNext[MS_DATA_XLATE]  = 1'b0;
    end else if (rfiTake) begin
      machineNext[MS_SCRATCH_SEL] = saveRestore_q[MS_SCRATCH_SEL];
      machineNext[MS_INSTR_XLATE] = saveRestore_q[MS_INSTR_XLATE];
      machineNext[MS_DATA_XLATE]  = saveRestore_q[MS_DATA_XLATE];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      machineState_q <= RST_WORD;
      saveRestore_q  <= RST_WORD;
    end else if (ce) begin
      machineState_q <= machineNext;
      if (missTake) saveRestore_q <= missSave;
    end
  end

  // Replacement way per lookaside alternates with each load
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instrWay_q <= 1'b0;
      dataWay_q  <= 1'b0;
    end else if (ce) begin
      if (tlbLoadInstr) instrWay_q <= ~instrWay_q;
      if (tlbLoadData)  dataWay_q  <= ~dataWay_q;
    end
  end

  // Lookaside load: compare word and reload word go out together, registered
  logic       instrWe_q, dataWe_q;
  tma_entry_s entry_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instrWe_q <= 1'b0;
      dataWe_q  <= 1'b0;
      entry_q   <= '0;
    end else if (ce) begin
      instrWe_q <= tlbLoadInstr;
      dataWe_q  <= tlbLoadData & ~tlbLoadInstr;
      if (tlbLoadInstr) begin
        entry_q <= '{cmpWord: instrCompare_q, physWord: reloadPhys_q, way: instrWay_q};
      end else if (tlbLoadData) begin
        entry_q <= '{cmpWord: dataCompare_q, physWord: reloadPhys_q, way: dataWay_q};
      end
    end
  end

  // Scratch steering: slots 32..35 hold the scratch bank, context registers stay untouched
  logic [5:0] gprSlot_q;
  logic       scratchHit;
  assign scratchHit = machineState_q[MS_SCRATCH_SEL] & (gprIndex[4:2] == 3'h0);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gprSlot_q <= 6'h00;
    end else if (ce) begin
      gprSlot_q <= scratchHit ? {4'h8, gprIndex[1:0]} : {1'b0, gprIndex};
    end
  end

  // Real mode pass-through and attributes
  logic       xlateOn;
  logic [3:0] attrSel;
  assign xlateOn = accIsFetch ? machineState_q[MS_INSTR_XLATE] : machineState_q[MS_DATA_XLATE];
  // Fetches never see write-through or coherence, whatever the translation supplied
  assign attrSel = accIsFetch ? (xlateOn ? (accXlateAttr & ATTR_ICACHE_MASK)
                                         : ATTR_REAL_INSTR)
                              : (xlateOn ? accXlateAttr : ATTR_REAL_DATA);

  logic        realValid_q, xlateNeeded_q;
  logic [31:0] physAddr_q;
  logic [3:0]  memAttr_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      realValid_q   <= 1'b0;
      xlateNeeded_q <= 1'b0;
      physAddr_q    <= RST_WORD;
      memAttr_q     <= 4'h0;
    end else if (ce) begin
      realValid_q   <= accValid & ~xlateOn;
      xlateNeeded_q <= accValid & xlateOn;
      if (accValid) begin
        physAddr_q <= accEa;
        memAttr_q  <= attrSel;
      end
    end
  end

  // Interrupt status: an event in the cycle of its clear still sets
  logic [2:0] irqEvents;
  logic       irq_q;
  assign irqEvents = {tlbLoadInstr | tlbLoadData,
                      missTake & ~missInfo.isInstr,
                      missTake & missInfo.isInstr};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_q <= 3'h0;
      irq_q       <= 1'b0;
    end else if (ce) begin
      irqStatus_q <= (irqStatus_q & ~(wrClear ? pwdata[2:0] : 3'h0)) | irqEvents;
      irq_q       <= |(((irqStatus_q & ~(wrClear ? pwdata[2:0] : 3'h0)) | irqEvents)
                       & irqEnable_q);
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign gprSlot          = gprSlot_q;
  assign instrLookasideWe = instrWe_q;
  assign dataLookasideWe  = dataWe_q;
  assign lookasideEntry   = entry_q;
  assign realValid        = realValid_q;
  assign xlateNeeded      = xlateNeeded_q;
  assign physAddr         = physAddr_q;
  assign memAttr          = memAttr_q;
  assign scratchSelect    = machineState_q[MS_SCRATCH_SEL];
  assign saveRestoreOne   = saveRestore_q;
  assign irq              = irq_q;

endmodule // tma_miss_assist

// *** tma_miss_assist_props.sv ***
// Port assertions for the lookaside miss assist block
`timescale 1ns/1ns
module tma_miss_assist_props
  import tma_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        missTake,
  input wire tma_miss_s   missInfo,
  input wire logic [3:0]  condFieldZero,
  input wire logic        rfiTake,
  input wire logic        tlbLoadInstr,
  input wire logic        tlbLoadData,
  input wire logic [4:0]  gprIndex,
  input wire logic        accValid,
  input wire logic        accIsFetch,
  input wire logic [31:0] accEa,
  input wire logic [3:0]  accXlateAttr,
  input wire logic [5:0]  gprSlot,
  input wire logic        instrLookasideWe,
  input wire logic        dataLookasideWe,
  input wire logic        realValid,
  input wire logic        xlateNeeded,
  input wire logic [31:0] physAddr,
  input wire logic [3:0]  memAttr,
  input wire logic        scratchSelect,
  input wire logic [31:0] saveRestoreOne
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_miss; ce && missTake; endsequence
  sequence s_fetch; ce && accValid && accIsFetch; endsequence
  sequence s_data; ce && accValid && !accIsFetch; endsequence
  property p_pass; ce && accValid |=> physAddr == $past(accEa); endproperty
  property p_rdata; s_data ##1 realValid |-> memAttr == 4'b0011; endproperty
  property p_rfetch; s_fetch ##1 realValid |-> memAttr == 4'b0001; endproperty
  property p_xfetch;
    s_fetch ##1 xlateNeeded |-> memAttr == ($past(accXlateAttr) & 4'b0101);
  endproperty
  property p_scr; s_miss |=> scratchSelect; endproperty
  property p_cond; s_miss |=> saveRestoreOne[31:28] == $past(condFieldZero); endproperty
  property p_kind;
    s_miss |=> saveRestoreOne[18] == $past(missInfo.isInstr)
      && saveRestoreOne[19] == $past(missInfo.protKey);
  endproperty
  property p_slot;
    ce |=> gprSlot == (($past(scratchSelect) && $past(gprIndex) < 5'd4)
      ? {1'b1, $past(gprIndex)} : {1'b0, $past(gprIndex)});
  endproperty
  property p_iload; ce && tlbLoadInstr |=> instrLookasideWe && !dataLookasideWe; endproperty
  property p_dload;
    ce && tlbLoadData && !tlbLoadInstr |=> dataLookasideWe && !instrLookasideWe;
  endproperty
  property p_rfi;
    ce && rfiTake && !missTake && !(psel && penable && pwrite)
      |=> scratchSelect == $past(saveRestoreOne[17]);
  endproperty
  a_pass: assert property (p_pass) else $error("address not passed through");
  a_rdata: assert property (p_rdata) else $error("bad real data attributes");
  a_rfetch: assert property (p_rfetch) else $error("bad real fetch attributes");
  a_xfetch: assert property (p_xfetch) else $error("fetch attributes not masked");
  a_scr: assert property (p_scr) else $error("scratch select not set");
  a_cond: assert property (p_cond) else $error("condition bits not saved");
  a_kind: assert property (p_kind) else $error("miss kind bits wrong");
  a_slot: assert property (p_slot) else $error("register slot wrong");
  a_iload: assert property (p_iload) else $error("instr load not written");
  a_dload: assert property (p_dload) else $error("data load not written");
  a_rfi: assert property (p_rfi) else $error("select not restored");
endmodule // tma_miss_assist_props

bind tma_miss_assist tma_miss_assist_props u_props (
  .clock            (clock),
  .rst_n            (rst_n),
  .ce               (ce),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .missTake         (missTake),
  .missInfo         (missInfo),
  .condFieldZero    (condFieldZero),
  .rfiTake          (rfiTake),
  .tlbLoadInstr     (tlbLoadInstr),
  .tlbLoadData      (tlbLoadData),
  .gprIndex         (gprIndex),
  .accValid         (accValid),
  .accIsFetch       (accIsFetch),
  .accEa            (accEa),
  .accXlateAttr     (accXlateAttr),
  .gprSlot          (gprSlot),
  .instrLookasideWe (instrLookasideWe),
  .dataLookasideWe  (dataLookasideWe),
  .realValid        (realValid),
  .xlateNeeded      (xlateNeeded),
  .physAddr         (physAddr),
  .memAttr          (memAttr),
  .scratchSelect    (scratchSelect),
  .saveRestoreOne   (saveRestoreOne)
);

// *** test_tma_miss_assist.sv ***
// Directed bench for the lookaside miss assist block
`timescale 1ns/1ns
module test_tma_miss_assist
  import tma_pkg::*;
;
  logic        clock, rst_n, ce, psel, penable, pwrite, pready, pslverr, err, irq;
  logic        missTake, littleEndian, rfiTake, tlbLoadInstr, tlbLoadData;
  logic        accValid, accIsFetch, realValid, xlateNeeded, scratchSelect;
  logic        instrLookasideWe, dataLookasideWe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, accEa, physAddr, saveRestoreOne, rd;
  logic [3:0]  condFieldZero, accXlateAttr, memAttr;
  logic [4:0]  gprIndex;
  logic [5:0]  gprSlot;
  tma_miss_s   missInfo;
  tma_entry_s  lookasideEntry;
  int          error_cnt, samples_checked;

  tma_miss_assist DUT (
    .clock            (clock),
    .rst_n            (rst_n),
    .ce               (ce),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .missTake         (missTake),
    .missInfo         (missInfo),
    .littleEndian     (littleEndian),
    .condFieldZero    (condFieldZero),
    .rfiTake          (rfiTake),
    .tlbLoadInstr     (tlbLoadInstr),
    .tlbLoadData      (tlbLoadData),
    .gprIndex         (gprIndex),
    .accValid         (accValid),
    .accIsFetch       (accIsFetch),
    .accEa            (accEa),
    .accXlateAttr     (accXlateAttr),
    .gprSlot          (gprSlot),
    .instrLookasideWe (instrLookasideWe),
    .dataLookasideWe  (dataLookasideWe),
    .lookasideEntry   (lookasideEntry),
    .realValid        (realValid),
    .xlateNeeded      (xlateNeeded),
    .physAddr         (physAddr),
    .memAttr          (memAttr),
    .scratchSelect    (scratchSelect),
    .saveRestoreOne   (saveRestoreOne),
    .irq              (irq)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request holds until pready is seen high at a rising edge; data is taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      error_cnt++;
      final_report();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Lets the pending pulses be taken, drops them, and waits for outputs
  task automatic settle();
    @(posedge clock);
    missTake     <= 1'b0;
    rfiTake      <= 1'b0;
    tlbLoadInstr <= 1'b0;
    tlbLoadData  <= 1'b0;
    accValid     <= 1'b0;
    #1;
  endtask

  task automatic miss(input tma_miss_s m, input logic [3:0] c);
    @(posedge clock);
    missTake      <= 1'b1;
    missInfo      <= m;
    condFieldZero <= c;
    settle();
  endtask

  task automatic access(input logic f, input logic [31:0] ea);
    @(posedge clock);
    accValid     <= 1'b1;
    accIsFetch   <= f;
    accEa        <= ea;
    accXlateAttr <= 4'hF;
    settle();
    chk(physAddr, ea);
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, missTake, littleEndian, rfiTake} = '0;
    {tlbLoadInstr, tlbLoadData, accValid, accIsFetch, paddr, pwdata} = '0;
    {accEa, condFieldZero, accXlateAttr, gprIndex, missInfo} = '0;
    ce = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, OFF_MACHINE_STATE, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h38, '0);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, OFF_SEGMENT_BASE + 8'h04, 32'h00AB_CDEF);
    apb(1'b1, OFF_SEGMENT_BASE + 8'h08, 32'h0012_3456);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0007);
    miss('{1'b1, 1'b0, 1'b1, SIZE_WORD, 32'h1234_5678}, 4'hA);
    chk({31'h0, scratchSelect}, 32'h0000_0001);
    chk(saveRestoreOne & 32'hF00F_0000, 32'hA00C_0000);
    apb(1'b0, OFF_INSTR_MISS_ADDR, '0);
    chk(rd, 32'h1234_5678);
    apb(1'b0, OFF_PRIMARY_GROUP, '0);
    chk(rd, 32'h0000_AA80);
    apb(1'b0, OFF_SECONDARY_GROUP, '0);
    chk(rd, 32'h0000_5540);
    apb(1'b0, OFF_INSTR_COMPARE, '0);
    chk(rd, 32'hD5E6_F788);
    for (int i = 2; i < 5; i++) begin
      @(posedge clock);
      gprIndex <= 5'(i);
      @(posedge clock);
      #1;
      chk({26'h0, gprSlot}, (i < 4) ? i + 32 : i);
    end
    @(posedge clock);
    condFieldZero <= saveRestoreOne[31:28];
    rfiTake       <= 1'b1;
    settle();
    chk({31'h0, scratchSelect}, 32'h0000_0000);
    littleEndian <= 1'b1;
    miss('{1'b0, 1'b1, 1'b0, SIZE_WORD, 32'h2345_6784}, 4'h5);
    chk(saveRestoreOne & 32'hF00F_0000, 32'h5001_0000);
    apb(1'b0, OFF_DATA_MISS_ADDR, '0);
    chk(rd, 32'h2345_6780);
    apb(1'b1, OFF_RELOAD_PHYS_ADDR, 32'h0ABC_D012);
    @(posedge clock);
    tlbLoadData <= 1'b1;
    settle();
    chk({31'h0, dataLookasideWe}, 32'h0000_0001);
    chk(lookasideEntry.cmpWord, 32'h891A_2B0D);
    chk(lookasideEntry.physWord, 32'h0ABC_D012);
    apb(1'b0, OFF_IRQ_STATUS, '0);
    chk(rd, 32'h0000_0007);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0007);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0000);
    miss('{1'b1, 1'b0, 1'b0, SIZE_WORD, 32'h1000_0000}, 4'h0);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0001);
    @(posedge clock);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, OFF_MACHINE_STATE, 32'h0000_0000);
    access(1'b0, 32'hC001_0004);
    chk({28'h0, memAttr}, 32'h0000_0003);
    chk({30'h0, xlateNeeded, realValid}, 32'h0000_0001);
    access(1'b1, 32'hC001_0008);
    chk({28'h0, memAttr}, 32'h0000_0001);
    apb(1'b1, OFF_MACHINE_STATE, 32'h0000_0020);
    access(1'b1, 32'hC001_000C);
    chk({28'h0, memAttr}, 32'h0000_0005);
    apb(1'b1, OFF_MACHINE_STATE, 32'h0000_0010);
    access(1'b0, 32'hC001_0010);
    chk({28'h0, memAttr}, 32'h0000_000F);
    chk({30'h0, xlateNeeded, realValid}, 32'h0000_0002);
    @(posedge clock);
    tlbLoadInstr <= 1'b1;
    settle();
    chk({31'h0, instrLookasideWe}, 32'h0000_0001);
    chk(lookasideEntry.cmpWord, 32'hD5E6_F780);
    chk(lookasideEntry.physWord, 32'h0ABC_D012);
    chk({31'h0, lookasideEntry.way}, 32'h0000_0000);
    // A miss while the clock enable is low must leave the select bit alone
    @(posedge clock);
    ce <= 1'b0;
    miss('{1'b1, 1'b0, 1'b0, SIZE_WORD, 32'h2000_0000}, 4'hF);
    chk({31'h0, scratchSelect}, 32'h0000_0000);
    @(posedge clock);
    ce <= 1'b1;
    final_report();
  end
endmodule // test_tma_miss_assist
